// >>> rtl/gauge_power_fet.sv
`timescale 1ns/1ps
// What this block does
// - Normal mode is default; it measures and refreshes data on every tick.
// - Idle entered only if idle enabled and mean current below threshold.
// - Offset calibration runs after idle qualifies, before idle begins.
// - Leave idle when mean current rises above threshold or wake detector fires.
// - Idle and deep idle measure only periodically at a slower rate.
// - Deep idle turns the high-frequency oscillator off.
// - Deep idle flag with zero wait time enters deep idle once idle.
// - Nonzero wait time enters deep idle when idle countdown reaches zero.
// - Host activity or idle exit conditions leave deep idle.
// - In deep idle, comm line may be held low up to 4 ms.
// - Drive charge and discharge switches, each through its own doubler.
// - Hardware fault, or firmware fault outside switch test, turns the relevant switch off.
// - Switch turns back on once its fault clears.
// - Switch-test command 0x74/0x75 lets test drive switches manually.
// - Protector thresholds decoded from three configuration fields by lookup tables.
// - 64 bytes user storage as two 32-byte blocks.
// - Voltage field selects 4.275 V to 4.450 V, 25 mV steps, default 111.
// - Charge current field selects 6, 13, 18, 28 mV, default 10.
// - Short circuit field selects 73 mV or 148 mV, default 0.
// - Firmware overrides only force switches off; hardware fault has final say.
module gauge_power_fet
  import gauge_pkg::*;
#(
  parameter int SLOW_DIV = 64,
  parameter int STRETCH_LEN = STRETCH_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [31:0] wrData,
  input wire logic wrStrobe,
  input wire logic rdStrobe,
  output logic [31:0] rdData,
  input wire logic [15:0] meanCurrent,
  input wire logic wakeDetect,
  input wire logic hostActivity,
  input wire logic hostDataLowNeeded,
  input wire logic hwChgFault,
  input wire logic hwDsgFault,
  input wire logic fwChgFault,
  input wire logic fwDsgFault,
  input wire logic calibDone,
  input wire logic tick,
  output logic measureStrobe,
  output logic calibStart,
  output logic hfOscOn,
  output logic commHoldLow,
  output logic chgDoublerOn,
  output logic dsgDoublerOn,
  output logic [1:0] powerMode
);

  initial begin
    if (SLOW_DIV < 2 || SLOW_DIV > 65535) $error("SLOW_DIV out of range");
    if (STRETCH_LEN < 1) $error("STRETCH_LEN out of range");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic idleEnable;
  logic [15:0] idleThresh;
  logic [15:0] waitTime;
  logic deepFlag;
  logic fwChgOff;
  logic fwDsgOff;
  logic [2:0] voltField;
  logic [5:0] currParam;
  logic testActive;
  logic testChg;
  logic testDsg;
  logic [5:0] flashAddr;
  logic [7:0] flashMem [FLASH_BYTES];
  power_state_e state;
  logic [15:0] countdown;
  logic [12:0] cellHighMv;
  logic [7:0] chgLimitMv;
  logic [7:0] shortLimitMv;

  logic wrHit;
  assign wrHit = wrStrobe;

  always_ff @(posedge clk) begin
    if (rst) begin
      idleEnable <= CONFIG_RESET;
      idleThresh <= IDLE_THRESH_RESET;
      waitTime <= WAIT_TIME_RESET;
      voltField <= VOLT_FIELD_RESET;
      currParam <= CURR_PARAM_RESET;
      flashAddr <= 6'h00;
    end else if (wrHit) begin
      case (addr)
        REG_CONFIG: idleEnable <= wrData[CFG_IDLE_EN_BIT];
        REG_IDLE_THRESH: idleThresh <= wrData[15:0];
        REG_WAIT_TIME: waitTime <= wrData[15:0];
        REG_PROT_VOLT: voltField <= wrData[2:0];
        REG_PROT_CURR: currParam <= wrData[5:0];
        REG_FLASH_ADDR: flashAddr <= wrData[5:0];
        default: ;
      endcase
    end
  end

  // Firmware overrides: they can only force switches off
  always_ff @(posedge clk) begin
    if (rst) begin
      fwChgOff <= 1'b0;
      fwDsgOff <= 1'b0;
    end else if (wrHit && addr == REG_CONTROL) begin
      fwChgOff <= wrData[CTL_FW_CHG_OFF_BIT];
      fwDsgOff <= wrData[CTL_FW_DSG_OFF_BIT];
    end
  end

  // Deep idle request flag: set by command, cleared by host activity wake
  always_ff @(posedge clk) begin
    if (rst) begin
      deepFlag <= 1'b0;
    end else if (wrHit && addr == REG_CONTROL && wrData[CTL_DEEP_REQ_BIT]) begin
      deepFlag <= 1'b1;
    end else if (state == ST_DEEP && hostActivity) begin
      deepFlag <= 1'b0;
    end
  end

  // Switch-test command: low byte must be one of the command codes
  always_ff @(posedge clk) begin
    if (rst) begin
      testActive <= 1'b0;
      testChg <= 1'b0;
      testDsg <= 1'b0;
    end else if (wrHit && addr == REG_SWITCH_TEST) begin
      testActive <= wrData[TST_CMD_LSB +: 8] == SWITCH_TEST_CMD_LO
        || wrData[TST_CMD_LSB +: 8] == SWITCH_TEST_CMD_HI;
      testChg <= wrData[TST_CHG_BIT];
      testDsg <= wrData[TST_DSG_BIT];
    end
  end

  // User storage, two 32-byte blocks selected by address bit 5
  always_ff @(posedge clk) begin
    if (wrHit && addr == REG_FLASH_DATA) begin
      flashMem[flashAddr] <= wrData[7:0];
    end
  end

  threshold_lut lut (
    .voltField(voltField),
    .chgField(currParam[OC_CHG_LSB +: 2]),
    .shortField(currParam[OC_SHORT_BIT]),
    .cellHighMv(cellHighMv),
    .chgLimitMv(chgLimitMv),
    .shortLimitMv(shortLimitMv)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      rdData <= 32'h0000_0000;
    end else if (rdStrobe) begin
      case (addr)
        REG_CONFIG: rdData <= {31'h0, idleEnable};
        REG_IDLE_THRESH: rdData <= {16'h0, idleThresh};
        REG_WAIT_TIME: rdData <= {16'h0, waitTime};
        REG_CONTROL: rdData <= {29'h0, fwDsgOff, fwChgOff, deepFlag};
        REG_PROT_VOLT: rdData <= {29'h0, voltField};
        REG_PROT_CURR: rdData <= {26'h0, currParam};
        REG_SWITCH_TEST: rdData <= {22'h0, testDsg, testChg, testActive ? SWITCH_TEST_CMD_LO : 8'h00};
        REG_STATUS: rdData <= {11'h0, countdown, state};
        REG_THRESH_OUT: rdData <= {3'h0, cellHighMv, chgLimitMv, shortLimitMv};
        REG_FLASH_ADDR: rdData <= {26'h0, flashAddr};
        REG_FLASH_DATA: rdData <= {24'h0, flashMem[flashAddr]};
        default: rdData <= 32'h0000_0000;
      endcase
    end else begin
      rdData <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power mode sequencer
  logic idleQualified;
  logic idleBroken;
  assign idleQualified = idleEnable && meanCurrent < idleThresh;
  assign idleBroken = meanCurrent > idleThresh || wakeDetect;

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= ST_NORMAL;
    end else begin
      case (state)
        ST_NORMAL: if (idleQualified) begin
          state <= ST_CALIB;
        end
        ST_CALIB: if (!idleQualified) begin
          state <= ST_NORMAL;
        end else if (calibDone) begin
          state <= ST_IDLE;
        end
        ST_IDLE: if (idleBroken) begin
          state <= ST_WAKE;
        end else if (deepFlag && waitTime == 16'h0) begin
          state <= ST_DEEP;
        end else if (waitTime != 16'h0 && countdown == 16'h0) begin
          state <= ST_DEEP;
        end
        ST_DEEP: if (hostActivity || idleBroken) begin
          state <= ST_WAKE;
        end
        ST_WAKE: state <= ST_NORMAL;
        default: state <= ST_NORMAL;
      endcase
    end
  end

  // Countdown on every tick while idle
  always_ff @(posedge clk) begin
    if (rst) begin
      countdown <= 16'h0;
    end else if (state == ST_CALIB && calibDone) begin
      countdown <= waitTime;
    end else if (state != ST_IDLE && state != ST_DEEP) begin
      countdown <= 16'h0;
    end else if (state == ST_IDLE && tick && countdown != 16'h0) begin
      countdown <= countdown - 16'h1;
    end
  end

  // Measurement pacing
  logic [15:0] slowCnt;
  always_ff @(posedge clk) begin
    if (rst) begin
      slowCnt <= 16'h0;
    end else if (state == ST_IDLE || state == ST_DEEP) begin
      slowCnt <= (slowCnt == 16'(SLOW_DIV - 1)) ? 16'h0 : slowCnt + 16'h1;
    end else begin
      slowCnt <= 16'h0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      measureStrobe <= 1'b0;
    end else begin
      case (state)
        ST_NORMAL, ST_WAKE: measureStrobe <= tick;
        ST_IDLE, ST_DEEP: measureStrobe <= tick && slowCnt == 16'h0;
        default: measureStrobe <= 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      calibStart <= 1'b0;
      hfOscOn <= 1'b1;
      powerMode <= 2'h0;
    end else begin
      calibStart <= state == ST_NORMAL && idleQualified;
      hfOscOn <= !(state == ST_DEEP);
      powerMode <= state == ST_DEEP ? 2'h2 : (state == ST_IDLE ? 2'h1 : 2'h0);
    end
  end

  // Communication stretch, bounded to the maximum hold time
  logic [31:0] holdCnt;
  always_ff @(posedge clk) begin
    if (rst) begin
      holdCnt <= 32'h0;
      commHoldLow <= 1'b0;
    end else if (state == ST_DEEP && hostDataLowNeeded && holdCnt < 32'(STRETCH_LEN)) begin
      holdCnt <= holdCnt + 32'h1;
      commHoldLow <= 1'b1;
    end else begin
      if (!hostDataLowNeeded) begin
        holdCnt <= 32'h0;
      end
      commHoldLow <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Switch drive: hardware fault overrides everything
  always_ff @(posedge clk) begin
    if (rst) begin
      chgDoublerOn <= 1'b0;
      dsgDoublerOn <= 1'b0;
    end else begin
      chgDoublerOn <= !hwChgFault && (testActive ? testChg : !(fwChgFault || fwChgOff));
      dsgDoublerOn <= !hwDsgFault && (testActive ? testDsg : !(fwDsgFault || fwDsgOff));
    end
  end

endmodule : gauge_power_fet

// >>> rtl/gauge_pkg.sv
package gauge_pkg;

  // Register offsets (byte addresses, one word each)
  localparam logic [7:0] REG_CONFIG = 8'h00;
  localparam logic [7:0] REG_IDLE_THRESH = 8'h04;
  localparam logic [7:0] REG_WAIT_TIME = 8'h08;
  localparam logic [7:0] REG_CONTROL = 8'h0C;
  localparam logic [7:0] REG_PROT_VOLT = 8'h10;
  localparam logic [7:0] REG_PROT_CURR = 8'h14;
  localparam logic [7:0] REG_SWITCH_TEST = 8'h18;
  localparam logic [7:0] REG_STATUS = 8'h1C;
  localparam logic [7:0] REG_THRESH_OUT = 8'h20;
  localparam logic [7:0] REG_FLASH_ADDR = 8'h24;
  localparam logic [7:0] REG_FLASH_DATA = 8'h28;

  // Switch test command codes
  localparam logic [7:0] SWITCH_TEST_CMD_LO = 8'h74;
  localparam logic [7:0] SWITCH_TEST_CMD_HI = 8'h75;

  // Field positions
  localparam int CFG_IDLE_EN_BIT = 0;
  localparam int CTL_DEEP_REQ_BIT = 0;
  localparam int CTL_FW_CHG_OFF_BIT = 1;
  localparam int CTL_FW_DSG_OFF_BIT = 2;
  localparam int TST_CMD_LSB = 0;
  localparam int TST_CHG_BIT = 8;
  localparam int TST_DSG_BIT = 9;
  localparam int OC_CHG_LSB = 0;
  localparam int OC_DSG_LSB = 2;
  localparam int OC_SHORT_BIT = 5;
  localparam int FLASH_BLOCK_BIT = 5;

  // Reset values
  localparam logic [2:0] VOLT_FIELD_RESET = 3'h7;
  localparam logic [5:0] CURR_PARAM_RESET = 6'h0A;
  localparam logic CONFIG_RESET = 1'b1;
  localparam logic [15:0] IDLE_THRESH_RESET = 16'h000A;
  localparam logic [15:0] WAIT_TIME_RESET = 16'h0000;

  // Flash geometry
  localparam int FLASH_BYTES = 64;
  localparam int FLASH_BLOCK_BYTES = 32;

  // Timing
  localparam int CLK_MHZ = 125;
  localparam int STRETCH_MAX_US = 4000;
  localparam int STRETCH_CYCLES = STRETCH_MAX_US * CLK_MHZ;
  localparam int CALIB_CYCLES = 16;

  typedef enum logic [4:0] {
    ST_NORMAL = 5'h01,
    ST_CALIB = 5'h02,
    ST_IDLE = 5'h04,
    ST_DEEP = 5'h08,
    ST_WAKE = 5'h10
  } power_state_e;

endpackage : gauge_pkg

// >>> rtl/threshold_lut.sv
`timescale 1ns/1ps
// Decodes protector configuration fields to thresholds (mV)
module threshold_lut
  import gauge_pkg::*;
(
  input wire logic [2:0] voltField,
  input wire logic [1:0] chgField,
  input wire logic shortField,
  output logic [12:0] cellHighMv,
  output logic [7:0] chgLimitMv,
  output logic [7:0] shortLimitMv
);

  always_comb begin
    cellHighMv = 13'(4275 + 25 * int'(voltField));
    case (chgField)
      2'h0: chgLimitMv = 8'h06;
      2'h1: chgLimitMv = 8'h0D;
      2'h2: chgLimitMv = 8'h12;
      default: chgLimitMv = 8'h1C;
    endcase
    shortLimitMv = shortField ? 8'h94 : 8'h49;
  end

endmodule : threshold_lut

// >>> test/host_link_model.sv
`timescale 1ns/1ps
module host_link_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic commHoldLow,
  output logic hostActivity,
  output logic done
);
  logic [2:0] len;
  // A transfer lasts four cycles and stalls while the device holds the line low
  always_ff @(posedge clk) begin
    done <= 1'b0;
    if (rst) begin
      hostActivity <= 1'b0;
      len <= 3'h0;
    end else if (start && !hostActivity) begin
      hostActivity <= 1'b1;
      len <= 3'h4;
    end else if (hostActivity && !commHoldLow) begin
      len <= len - 3'h1;
      if (len == 3'h1) begin
        hostActivity <= 1'b0;
        done <= 1'b1;
      end
    end
  end
endmodule : host_link_model

// >>> test/gauge_power_fet_asserts.sv
`timescale 1ns/1ps
module gauge_power_fet_asserts
  import gauge_pkg::*;
#(
  parameter int STRETCH_LEN = STRETCH_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wakeDetect,
  input wire logic hostActivity,
  input wire logic hwChgFault,
  input wire logic hwDsgFault,
  input wire logic calibStart,
  input wire logic hfOscOn,
  input wire logic commHoldLow,
  input wire logic chgDoublerOn,
  input wire logic dsgDoublerOn,
  input wire logic [1:0] powerMode
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [31:0] holdCount;
  always_ff @(posedge clk) begin
    if (rst || !commHoldLow) holdCount <= 32'h0;
    else holdCount <= holdCount + 32'h1;
  end
  a_hw_chg_off: assert property (hwChgFault |=> !chgDoublerOn) else $error("charge switch on under fault");
  a_hw_dsg_off: assert property (hwDsgFault |=> !dsgDoublerOn) else $error("discharge switch on under fault");
  a_osc_deep_only: assert property (!hfOscOn |-> powerMode == 2'h2 || $past(powerMode) == 2'h2)
    else $error("oscillator off outside deep idle");
  a_osc_normal_on: assert property (powerMode == 2'h0 && $past(powerMode) == 2'h0 |-> hfOscOn)
    else $error("oscillator off in normal");
  a_calib_before_idle: assert property (powerMode == 2'h1 && $past(powerMode) == 2'h0
    |-> $past(calibStart) || $past(calibStart, 2) || $past(calibStart, 3)) else $error("idle without calibration");
  a_wake_leaves_idle: assert property (powerMode == 2'h1 && wakeDetect |-> ##[1:4] powerMode == 2'h0)
    else $error("wake did not leave idle");
  a_host_leaves_deep: assert property (powerMode == 2'h2 && hostActivity |-> ##[1:4] powerMode != 2'h2)
    else $error("host activity did not leave deep idle");
  a_deep_from_idle: assert property (powerMode == 2'h2 && $past(powerMode) != 2'h2 |-> $past(powerMode) == 2'h1)
    else $error("deep idle entered from outside idle");
  a_stretch_bound: assert property (holdCount <= 32'(STRETCH_LEN)) else $error("line held low too long");
endmodule : gauge_power_fet_asserts
bind gauge_power_fet gauge_power_fet_asserts #(.STRETCH_LEN(STRETCH_LEN)) i_asserts (.clk(clk), .rst(rst),
  .wakeDetect(wakeDetect), .hostActivity(hostActivity), .hwChgFault(hwChgFault), .hwDsgFault(hwDsgFault),
  .calibStart(calibStart), .hfOscOn(hfOscOn), .commHoldLow(commHoldLow), .chgDoublerOn(chgDoublerOn),
  .dsgDoublerOn(dsgDoublerOn), .powerMode(powerMode));

// >>> test/tb.sv
`timescale 1ns/1ps
module tb;
  import gauge_pkg::*;
  logic clk, rst, wrStrobe, rdStrobe, wakeDetect, hostActivity, hostDataLowNeeded, calibDone, tick;
  logic hwChgFault, hwDsgFault, fwChgFault, fwDsgFault, measureStrobe, calibStart, hfOscOn, commHoldLow;
  logic chgDoublerOn, dsgDoublerOn, start, done;
  logic [1:0] powerMode, k;
  logic [3:0] f;
  logic [7:0] addr;
  logic [15:0] meanCurrent;
  logic [31:0] wrData, rdData, rv;
  int n_errors, checks_done, seed, i;
  gauge_power_fet #(.SLOW_DIV(4), .STRETCH_LEN(20)) i_gauge_power_fet (.clk(clk), .rst(rst), .addr(addr),
    .wrData(wrData), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData), .meanCurrent(meanCurrent),
    .wakeDetect(wakeDetect), .hostActivity(hostActivity), .hostDataLowNeeded(hostDataLowNeeded),
    .hwChgFault(hwChgFault), .hwDsgFault(hwDsgFault), .fwChgFault(fwChgFault), .fwDsgFault(fwDsgFault),
    .calibDone(calibDone), .tick(tick), .measureStrobe(measureStrobe), .calibStart(calibStart), .hfOscOn(hfOscOn),
    .commHoldLow(commHoldLow), .chgDoublerOn(chgDoublerOn), .dsgDoublerOn(dsgDoublerOn), .powerMode(powerMode));
  host_link_model i_host_link_model (.clk(clk), .rst(rst), .start(start), .commHoldLow(commHoldLow),
    .hostActivity(hostActivity), .done(done));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] thr(input int v, input int c, input int s);
    logic [7:0] cm;
    cm = (c == 0) ? 8'h06 : (c == 1) ? 8'h0D : (c == 2) ? 8'h12 : 8'h1C;
    return {3'h0, 13'(13'h10B3 + 13'h0019 * v), cm, (s != 0) ? 8'h94 : 8'h49};
  endfunction : thr
  function automatic logic sw(input logic hw, input logic fw, input logic b, input logic test);
    return !hw && (test ? b : !(fw || b));
  endfunction : sw
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wrData <= d;
    wrStrobe <= 1'b1;
    @(posedge clk);
    wrStrobe <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rdStrobe <= 1'b1;
    @(posedge clk);
    rdStrobe <= 1'b0;
    @(negedge clk);
    d = rdData;
  endtask : rd
  task automatic waitMode(input logic [1:0] m);
    for (int n = 0; n < 300 && powerMode !== m; n++) @(negedge clk);
    chk("powerMode", 32'(m), 32'(powerMode));
  endtask : waitMode
  task automatic goIdle();
    for (int n = 0; n < 50 && calibStart !== 1'b1; n++) @(negedge clk);
    chk("calibStart", 32'h1, 32'(calibStart));
    @(posedge clk);
    calibDone <= 1'b1;
    @(posedge clk);
    calibDone <= 1'b0;
  endtask : goIdle
  task automatic results();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) tick <= ($random(seed) & 3) == 0;
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    results();
  end
  initial begin
    seed = 32'h34C44907;
    {rst, wrStrobe, rdStrobe, wakeDetect, hostDataLowNeeded, calibDone, tick, start} = 8'hA0 >> 7 << 7;
    {hwChgFault, hwDsgFault, fwChgFault, fwDsgFault} = 4'h0;
    addr = 8'h00;
    wrData = 32'h0;
    meanCurrent = 16'hFFFF;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(negedge clk);
    chk("chgOn", 32'h1, 32'(chgDoublerOn));
    for (i = 0; i < 8; i++) begin
      k[0] = tick;
      @(negedge clk);
      chk("measureStrobe", 32'(k[0]), 32'(measureStrobe));
    end
    rd(REG_CONFIG, rv);
    chk("config", 32'h1, rv);
    rd(REG_THRESH_OUT, rv);
    chk("thrReset", thr(7, 2, 0), rv);
    rd(8'h40, rv);
    chk("unmapped", 32'h0, rv);
    wr(REG_FLASH_ADDR, 32'h21);
    wr(REG_FLASH_DATA, 32'h5A);
    rd(REG_FLASH_DATA, rv);
    chk("flash", 32'h5A, rv);
    for (i = 0; i < 8; i++) begin
      wr(REG_PROT_VOLT, 32'(i));
      wr(REG_PROT_CURR, 32'({i[0], 3'h0, i[1:0]}));
      rd(REG_THRESH_OUT, rv);
      chk("thresh", thr(i, i % 4, i % 2), rv);
    end
    for (i = 0; i < 32; i++) begin
      f = 4'($random(seed));
      k = 2'($random(seed));
      wr(REG_CONTROL, 32'({k, 1'b0}));
      wr(REG_SWITCH_TEST, (i < 16) ? 32'h0 : 32'({k, 7'h3A, f[3]}));
      {fwDsgFault, fwChgFault, hwDsgFault, hwChgFault} <= f;
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk("chg", 32'(sw(f[0], f[2], k[0], i >= 16)), 32'(chgDoublerOn));
      chk("dsg", 32'(sw(f[1], f[3], k[1], i >= 16)), 32'(dsgDoublerOn));
    end
    {fwDsgFault, fwChgFault, hwDsgFault, hwChgFault} <= 4'h0;
    wr(REG_SWITCH_TEST, 32'h0);
    wr(REG_CONTROL, 32'h0);
    wr(REG_CONFIG, 32'h0);
    meanCurrent <= 16'h0005;
    repeat (20) @(posedge clk);
    chk("disabled", 32'h0, 32'(powerMode));
    wr(REG_CONFIG, 32'h1);
    goIdle();
    waitMode(2'h1);
    wakeDetect <= 1'b1;
    waitMode(2'h0);
    wakeDetect <= 1'b0;
    goIdle();
    waitMode(2'h1);
    meanCurrent <= 16'hFFFF;
    waitMode(2'h0);
    wr(REG_CONTROL, 32'h1);
    meanCurrent <= 16'h0005;
    goIdle();
    waitMode(2'h2);
    chk("hfOscOn", 32'h0, 32'(hfOscOn));
    hostDataLowNeeded <= 1'b1;
    repeat (3) @(negedge clk);
    chk("commHoldLow", 32'h1, 32'(commHoldLow));
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    for (int n = 0; n < 100 && done !== 1'b1; n++) @(negedge clk);
    chk("hostDone", 32'h1, 32'(done));
    hostDataLowNeeded <= 1'b0;
    waitMode(2'h0);
    meanCurrent <= 16'hFFFF;
    wr(REG_WAIT_TIME, 32'h3);
    meanCurrent <= 16'h0005;
    goIdle();
    waitMode(2'h1);
    waitMode(2'h2);
    meanCurrent <= 16'hFFFF;
    waitMode(2'h0);
    results();
  end
endmodule : tb
